// ===== hdl/strap_cfg_pkg.sv
// constants, field layouts and strap decoding for the strap configuration loader
package strap_cfg_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLOCK_MHZ = 250;
   localparam int unsigned BURN_TIME_MS = 100;
   localparam int unsigned BURN_CYCLES = BURN_TIME_MS * CLOCK_MHZ * 1000;
   localparam int unsigned BURN_W = 25;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] OFS_SOURCE_SEL = 8'h00;
   localparam logic [7:0] OFS_NVM_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_OC_THRESHOLD = 8'h0C;
   localparam logic [7:0] OFS_PRIMARY_CFG = 8'h10;
   localparam logic [7:0] OFS_ADDR_LOOP = 8'h14;
   localparam logic [7:0] OFS_VOUT_CFG = 8'h18;

   // strap_source_select bits: 1 = stored value, 0 = strap
   localparam int unsigned SEL_OCL = 0;
   localparam int unsigned SEL_ADDR = 1;
   localparam int unsigned SEL_LOOP = 2;
   localparam int unsigned SEL_VOUT = 3;
   localparam logic [3:0] SOURCE_SEL_RESET = 4'h0;

   // nvm command bits
   localparam int unsigned CMD_STORE = 0;
   localparam int unsigned CMD_RESTORE = 1;

   // status bits
   localparam int unsigned ST_STRAPS_DONE = 0;
   localparam int unsigned ST_EXT_DIV = 1;
   localparam int unsigned ST_POR_FAULT = 2;
   localparam int unsigned ST_POWER_ON = 3;
   localparam int unsigned ST_BUS_EN = 4;
   localparam int unsigned ST_BURN_BUSY = 5;

   // field positions
   localparam int unsigned F_SS_LSB = 0;
   localparam int unsigned F_HICCUP = 8;
   localparam int unsigned F_LOOP_LSB = 8;
   localparam int unsigned F_CLASS_LSB = 8;

   // ****************************************
   // strap codes and values
   // ****************************************
   localparam int unsigned CODE_W = 5;
   localparam logic [1:0] PIN_PRIMARY = 2'h0;
   localparam logic [1:0] PIN_OUTPUT = 2'h3;
   localparam logic [4:0] PRIMARY_CODE_MAX = 5'h16;
   localparam logic [4:0] PRIMARY_EXT_FIRST = 5'h0C;
   localparam logic [4:0] CLASS1_FIRST = 5'h05;
   localparam logic [4:0] CLASS2_FIRST = 5'h0F;
   localparam logic [7:0] OCL_25A = 8'h19;
   localparam logic [7:0] OCL_20A = 8'h14;
   localparam logic [7:0] OCL_15A = 8'h0F;
   localparam logic [1:0] SS_0P5MS = 2'h0;
   localparam logic [1:0] SS_2MS = 2'h1;
   localparam logic [1:0] SS_4MS = 2'h2;
   localparam logic [1:0] SS_8MS = 2'h3;
   localparam logic [1:0] CLASS_LOW = 2'h0;
   localparam logic [1:0] CLASS_MID = 2'h1;
   localparam logic [1:0] CLASS_HIGH = 2'h2;

   // stored values at reset
   localparam logic [7:0] NV_OC_RESET = 8'h19;
   localparam logic [4:0] NV_ADDR_RESET = 5'h00;
   localparam logic [4:0] NV_LOOP_RESET = 5'h00;
   localparam logic [4:0] NV_VOUT_RESET = 5'h00;

   typedef struct packed {
      logic [7:0] current_limit_level;
      logic [1:0] ss;
      logic hiccup;
      logic ext_div;
   } primary_cfg_t;

   // primary strap code to limit, soft start, response, divider
   function automatic primary_cfg_t decode_primary(input logic [4:0] code);
      primary_cfg_t r;
      logic [4:0] c;
      logic [3:0] j;
      c = (code > PRIMARY_CODE_MAX) ? PRIMARY_CODE_MAX : code;
      j = 4'(c - PRIMARY_EXT_FIRST);
      r.ext_div = (c >= PRIMARY_EXT_FIRST);
      if (!r.ext_div) begin
         r.current_limit_level = (c < 5'h04) ? OCL_25A : (c < 5'h08) ? OCL_20A : OCL_15A;
         r.ss = c[0] ? SS_2MS : SS_0P5MS;
         r.hiccup = c[1];
      end else begin
         r.current_limit_level = (j < 4'h4) ? OCL_25A : (j < 4'h8) ? OCL_20A : OCL_15A;
         r.ss = (j < 4'h8) ? j[1:0] : (j == 4'h8) ? SS_0P5MS : (j == 4'h9) ? SS_2MS : SS_8MS;
         r.hiccup = 1'b1;
      end
      return r;
   endfunction

   // output level code to range class
   function automatic logic [1:0] vout_class(input logic [4:0] code);
      return (code < CLASS1_FIRST) ? CLASS_LOW : (code < CLASS2_FIRST) ? CLASS_MID : CLASS_HIGH;
   endfunction
endpackage

// ===== hdl/strap_cfg_ifs.sv
// internal carriers between the loader, the strap sampler and the bus slave
`timescale 1ns/1ps
interface strap_if;
   logic start;
   logic done;
   logic [3:0][4:0] codes;
   modport sampler(input start, output done, output codes);
   modport loader(output start, input done, input codes);
endinterface

interface regbus_if;
   logic wr;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic err;
   modport slave(output wr, output addr, output wdata, input rdata, input err);
   modport regs(input wr, input addr, input wdata, output rdata, output err);
endinterface

// ===== hdl/strap_sampler.sv
// walks the four strap pins in order and collects their resistance codes
`timescale 1ns/1ps
module strap_sampler (
   input wire logic clock,
   input wire logic rst,
   strap_if.sampler sif,
   input wire logic sense_done,
   input wire logic [4:0] sense_code,
   output logic [1:0] sense_pin_q,
   output logic sense_req_q
);
   import strap_cfg_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_REQ, S_RELEASE} samp_state_t;
   samp_state_t state_q;
   logic done_m_q, done_s_q;
   logic [4:0] code_m_q, code_s_q;
   logic done_q;
   logic [3:0][4:0] codes_q;

   // ****************************************
   // pin synchronisers
   // ****************************************
   always_ff @(posedge clock) begin
      done_m_q <= sense_done;
      done_s_q <= done_m_q;
      code_m_q <= sense_code;
      code_s_q <= code_m_q;
   end

   // ****************************************
   // sequence
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= S_IDLE;
         sense_pin_q <= PIN_PRIMARY;
         sense_req_q <= 1'b0;
         done_q <= 1'b0;
         codes_q <= '0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (sif.start) begin
                  sense_pin_q <= PIN_PRIMARY;
                  sense_req_q <= 1'b1;
                  done_q <= 1'b0;
                  state_q <= S_REQ;
               end
            end
            S_REQ: begin
               if (done_s_q) begin
                  codes_q[sense_pin_q] <= code_s_q;
                  sense_req_q <= 1'b0;
                  state_q <= S_RELEASE;
               end
            end
            S_RELEASE: begin
               if (!done_s_q) begin
                  if (sense_pin_q == PIN_OUTPUT) begin
                     done_q <= 1'b1;
                     state_q <= S_IDLE;
                  end else begin
                     sense_pin_q <= sense_pin_q + 2'h1;
                     sense_req_q <= 1'b1;
                     state_q <= S_REQ;
                  end
               end
            end
         endcase
      end
   end

   assign sif.done = done_q;
   assign sif.codes = codes_q;
endmodule

// ===== hdl/apb_cfg_slave.sv
// apb slave front end: one wait state, registered answers
`timescale 1ns/1ps
module apb_cfg_slave (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready_q,
   output logic [31:0] prdata_q,
   output logic pslverr_q,
   regbus_if.slave rb
);
   wire access = psel && penable;
   wire last = access && pready_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= access && !pready_q;
         if (access && !pready_q) begin
            prdata_q <= pwrite ? 32'h0 : rb.rdata;
            pslverr_q <= rb.err;
         end else if (last) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
         end
      end
   end

   assign rb.wr = last && pwrite && !rb.err;
   assign rb.addr = paddr;
   assign rb.wdata = pwdata;
endmodule

// ===== hdl/pin_strap_config_loader.sv
// strap configuration loader: power-up sequencing, strap decode, source select, store and restore
//
// Notes on behaviour
// - initial values come from four strap pins
// - select bit picks strap or stored value
// - straps read primary, address, loop, output level
// - external divider ignores output level strap
// - internal divider: output level sets voltage, range
// - limit source bit picks backup or strap
// - strapped limit overwrites overcurrent threshold register
// - one fault response for temperature, over, under
// - internal codes: 25/20/15 A, 0.5/2 ms
// - external codes: always hiccup, up to 8 ms
// - detection and bus after all supplies ok
// - power lost mid-burn gives reset fault later
// - single input: any supply/enable order starts
// - split rail: power, bias, enable all needed
`timescale 1ns/1ps
module pin_strap_config_loader #(
   parameter int unsigned burn_cycles = strap_cfg_pkg::BURN_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready_q,
   output logic [31:0] prdata_q,
   output logic pslverr_q,
   input wire logic input_supply_ok,
   input wire logic bias_supply_ok,
   input wire logic driver_bias_rail_ok,
   input wire logic enable_in,
   input wire logic split_rail_mode,
   input wire logic sense_done,
   input wire logic [4:0] sense_code,
   output logic [1:0] sense_pin_q,
   output logic sense_req_q,
   output logic bus_enable_q,
   output logic power_on_q,
   output logic ext_divider_q,
   output logic [7:0] current_limit_level_q,
   output logic [1:0] soft_start_q,
   output logic fault_hiccup_q,
   output logic [4:0] bus_address_q,
   output logic [4:0] loop_config_q,
   output logic [4:0] output_level_q,
   output logic [1:0] output_range_q,
   output logic por_fault_q
);
   import strap_cfg_pkg::*;

   // ****************************************
   // supply synchronisers
   // ****************************************
   logic [4:0] sup_m_q, sup_s_q;
   always_ff @(posedge clock) begin
      sup_m_q <= {split_rail_mode, enable_in, driver_bias_rail_ok, bias_supply_ok, input_supply_ok};
      sup_s_q <= sup_m_q;
   end
   wire vin_ok = sup_s_q[0];
   wire bias_ok = sup_s_q[1];
   wire drv_ok = sup_s_q[2];
   wire en_ok = sup_s_q[3];
   wire split = sup_s_q[4];
   wire supplies_ok = vin_ok && bias_ok && drv_ok;

   // ****************************************
   // sub blocks
   // ****************************************
   strap_if sif();
   regbus_if rb();

   strap_sampler u_sampler (
      .clock(clock),
      .rst(rst),
      .sif(sif.sampler),
      .sense_done(sense_done),
      .sense_code(sense_code),
      .sense_pin_q(sense_pin_q),
      .sense_req_q(sense_req_q)
   );

   apb_cfg_slave u_apb (
      .clock(clock),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pready_q(pready_q),
      .prdata_q(prdata_q),
      .pslverr_q(pslverr_q),
      .rb(rb.slave)
   );

   // ****************************************
   // state
   // ****************************************
   typedef enum logic [1:0] {L_OFF, L_START, L_SENSE, L_READY} load_state_t;
   load_state_t state_q;
   logic [3:0] source_sel_q;
   logic [7:0] nv_oc_q;
   logic [4:0] nv_addr_q, nv_loop_q, nv_vout_q;
   logic burn_busy_q, nv_corrupt_q, straps_done_q;
   logic [BURN_W-1:0] burn_cnt_q;

   // ****************************************
   // decode
   // ****************************************
   wire [4:0] code_primary = sif.codes[0];
   wire [4:0] code_addr = sif.codes[1];
   wire [4:0] code_loop = sif.codes[2];
   wire [4:0] code_vout = sif.codes[3];
   wire primary_cfg_t pcfg = decode_primary(code_primary);
   wire ext_div = pcfg.ext_div;
   wire [4:0] vout_pick = (ext_div || source_sel_q[SEL_VOUT]) ? nv_vout_q : code_vout;
   wire [1:0] class_pick = ext_div ? CLASS_LOW : vout_class(vout_pick);
   wire [4:0] addr_pick = source_sel_q[SEL_ADDR] ? nv_addr_q : code_addr;
   wire [4:0] loop_pick = source_sel_q[SEL_LOOP] ? nv_loop_q : code_loop;
   wire [7:0] ocl_pick = source_sel_q[SEL_OCL] ? nv_oc_q : pcfg.current_limit_level;
   wire apply = (state_q == L_SENSE) && sif.done;
   wire power_loss = !supplies_ok;

   // ****************************************
   // register access
   // ****************************************
   wire wr_sel = rb.wr && (rb.addr == OFS_SOURCE_SEL);
   wire wr_cmd = rb.wr && (rb.addr == OFS_NVM_CMD);
   wire wr_oc = rb.wr && (rb.addr == OFS_OC_THRESHOLD);
   wire wr_al = rb.wr && (rb.addr == OFS_ADDR_LOOP);
   wire wr_vo = rb.wr && (rb.addr == OFS_VOUT_CFG);
   wire store_req = wr_cmd && rb.wdata[CMD_STORE] && !burn_busy_q;
   wire restore_req = wr_cmd && rb.wdata[CMD_RESTORE] && !burn_busy_q;
   wire burn_end = burn_busy_q && (burn_cnt_q == BURN_W'(burn_cycles - 1));
   wire [31:0] status_word = {26'h0, burn_busy_q, bus_enable_q, power_on_q, por_fault_q,
      ext_divider_q, straps_done_q};
   wire [31:0] vout_word = {22'h0, output_range_q, 3'h0, output_level_q};
   wire [31:0] al_word = {19'h0, loop_config_q, 3'h0, bus_address_q};
   wire [31:0] pcfg_word = {23'h0, fault_hiccup_q, 6'h0, soft_start_q};

   always_comb begin
      rb.err = 1'b0;
      unique case (rb.addr)
         OFS_SOURCE_SEL: rb.rdata = {28'h0, source_sel_q};
         OFS_NVM_CMD: rb.rdata = {31'h0, burn_busy_q};
         OFS_STATUS: rb.rdata = status_word;
         OFS_OC_THRESHOLD: rb.rdata = {24'h0, current_limit_level_q};
         OFS_PRIMARY_CFG: rb.rdata = pcfg_word;
         OFS_ADDR_LOOP: rb.rdata = al_word;
         OFS_VOUT_CFG: rb.rdata = vout_word;
         default: begin
            rb.rdata = 32'h0;
            rb.err = 1'b1;
         end
      endcase
   end

   // ****************************************
   // power-up sequence
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= L_OFF;
         straps_done_q <= 1'b0;
         bus_enable_q <= 1'b0;
         power_on_q <= 1'b0;
         por_fault_q <= 1'b0;
      end else if (power_loss) begin
         state_q <= L_OFF;
         straps_done_q <= 1'b0;
         bus_enable_q <= 1'b0;
         power_on_q <= 1'b0;
      end else begin
         unique case (state_q)
            L_OFF: begin
               state_q <= L_START;
               bus_enable_q <= 1'b1;
               por_fault_q <= nv_corrupt_q;
            end
            L_START: state_q <= L_SENSE;
            L_SENSE: begin
               if (sif.done) begin
                  state_q <= L_READY;
                  straps_done_q <= 1'b1;
               end
            end
            L_READY: power_on_q <= en_ok && (split ? (vin_ok && bias_ok) : vin_ok);
         endcase
      end
   end
   assign sif.start = (state_q == L_START);

   // ****************************************
   // command values
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         source_sel_q <= SOURCE_SEL_RESET;
         ext_divider_q <= 1'b0;
         current_limit_level_q <= NV_OC_RESET;
         soft_start_q <= SS_0P5MS;
         fault_hiccup_q <= 1'b0;
         bus_address_q <= NV_ADDR_RESET;
         loop_config_q <= NV_LOOP_RESET;
         output_level_q <= NV_VOUT_RESET;
         output_range_q <= CLASS_LOW;
      end else begin
         if (wr_sel)
            source_sel_q <= rb.wdata[3:0];
         if (apply) begin
            ext_divider_q <= ext_div;
            current_limit_level_q <= ocl_pick;
            soft_start_q <= pcfg.ss;
            fault_hiccup_q <= pcfg.hiccup;
            bus_address_q <= addr_pick;
            loop_config_q <= loop_pick;
            output_level_q <= vout_pick;
            output_range_q <= class_pick;
         end else if (restore_req) begin
            current_limit_level_q <= nv_oc_q;
            bus_address_q <= nv_addr_q;
            loop_config_q <= nv_loop_q;
            output_level_q <= nv_vout_q;
            output_range_q <= ext_divider_q ? CLASS_LOW : vout_class(nv_vout_q);
         end else begin
            if (wr_oc)
               current_limit_level_q <= rb.wdata[7:0];
            if (wr_al) begin
               bus_address_q <= rb.wdata[4:0];
               loop_config_q <= rb.wdata[F_LOOP_LSB +: CODE_W];
            end
            if (wr_vo && !ext_divider_q) begin
               output_level_q <= rb.wdata[4:0];
               output_range_q <= vout_class(rb.wdata[4:0]);
            end
         end
      end
   end

   // ****************************************
   // non-volatile store
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         burn_busy_q <= 1'b0;
         burn_cnt_q <= '0;
         nv_corrupt_q <= 1'b0;
         nv_oc_q <= NV_OC_RESET;
         nv_addr_q <= NV_ADDR_RESET;
         nv_loop_q <= NV_LOOP_RESET;
         nv_vout_q <= NV_VOUT_RESET;
      end else if (burn_busy_q && power_loss) begin
         burn_busy_q <= 1'b0;
         nv_corrupt_q <= 1'b1;
      end else if (store_req) begin
         burn_busy_q <= 1'b1;
         burn_cnt_q <= '0;
      end else if (burn_end) begin
         burn_busy_q <= 1'b0;
         nv_corrupt_q <= 1'b0;
         nv_oc_q <= current_limit_level_q;
         nv_addr_q <= bus_address_q;
         nv_loop_q <= loop_config_q;
         nv_vout_q <= output_level_q;
      end else if (burn_busy_q) begin
         burn_cnt_q <= burn_cnt_q + BURN_W'(1);
      end
   end
endmodule

// ===== tb/strap_sensor_model.sv
// behavioural resistance sensor answering the loader's strap requests
`timescale 1ns/1ps
module strap_sensor_model (
   input wire logic clock,
   input wire logic sense_req_q,
   input wire logic [1:0] sense_pin_q,
   input wire logic [3:0][4:0] codes,
   input wire logic [2:0] lag,
   output logic sense_done,
   output logic [4:0] sense_code
);
   logic [2:0] wait_q;
   initial begin
      sense_done = 1'b0;
      sense_code = 5'h00;
      wait_q = 3'h0;
   end
   // ****************************************
   // measure, answer after lag, release after request drops
   // ****************************************
   always @(posedge clock) begin
      if (sense_req_q && !sense_done) begin
         if (wait_q == lag) begin
            sense_done <= 1'b1;
            sense_code <= codes[sense_pin_q];
         end else begin
            wait_q <= wait_q + 3'h1;
         end
      end else if (!sense_req_q && sense_done) begin
         sense_done <= 1'b0;
         sense_code <= ~sense_code;
         wait_q <= 3'h0;
      end
   end
endmodule

// ===== tb/pin_strap_config_loader_chk.sv
// port checks for the strap configuration loader
`timescale 1ns/1ps
module pin_strap_config_loader_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready_q,
   input wire logic [31:0] prdata_q,
   input wire logic pslverr_q,
   input wire logic input_supply_ok,
   input wire logic bias_supply_ok,
   input wire logic enable_in,
   input wire logic split_rail_mode,
   input wire logic sense_req_q,
   input wire logic [1:0] sense_pin_q,
   input wire logic bus_enable_q,
   input wire logic power_on_q,
   input wire logic ext_divider_q,
   input wire logic fault_hiccup_q,
   input wire logic [1:0] soft_start_q,
   input wire logic [4:0] bus_address_q,
   input wire logic [4:0] output_level_q,
   input wire logic [1:0] output_range_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ****************************************
   // assertions
   // ****************************************
   a_ready_timing: assert property (psel && $rose(penable) |=> pready_q ##1 !pready_q)
      else $error("ready not a pulse one cycle after access");
   a_err_zero: assert property (pslverr_q |-> pready_q && prdata_q == 32'h0)
      else $error("error response malformed");
   a_supply_drop: assert property (!input_supply_ok [*4] |=> !bus_enable_q)
      else $error("bus enabled without supply");
   a_sense_gated: assert property ($rose(sense_req_q) |-> bus_enable_q)
      else $error("sensing before supplies ready");
   a_pin_step: assert property (
      sense_pin_q != $past(sense_pin_q) |-> sense_pin_q == 2'($past(sense_pin_q) + 2'h1) || sense_pin_q == 2'h0)
      else $error("strap pins out of order");
   a_ext_range: assert property (ext_divider_q |-> output_range_q == 2'h0)
      else $error("range from level strap with external divider");
   a_ext_hiccup: assert property (ext_divider_q |-> fault_hiccup_q)
      else $error("external divider without hiccup");
   a_range_class: assert property (
      !ext_divider_q && $stable(output_level_q) |-> output_range_q ==
      (output_level_q < 5'h05 ? 2'h0 : output_level_q < 5'h0F ? 2'h1 : 2'h2))
      else $error("range class wrong for level code");
   a_enable_off: assert property (!enable_in [*4] |=> !power_on_q)
      else $error("power on without enable");
   a_split_bias: assert property (split_rail_mode && !bias_supply_ok [*4] |=> !power_on_q)
      else $error("split rail on without bias");
   a_hold_straps: assert property (
      power_on_q && $past(power_on_q) && !$past(pready_q) |-> $stable(soft_start_q) && $stable(bus_address_q))
      else $error("strap values changed while running");
endmodule

// ===== tb/pin_strap_config_loader_test.sv
// self-checking bench for the strap configuration loader
`timescale 1ns/1ps
module pin_strap_config_loader_test;
   import strap_cfg_pkg::*;
   logic clock, rst, psel, penable, pwrite, pready_q, pslverr_q, er;
   logic [7:0] paddr, current_limit_level_q;
   logic [31:0] pwdata, prdata_q, rd;
   logic input_supply_ok, bias_supply_ok, driver_bias_rail_ok, enable_in, split_rail_mode;
   logic sense_done, sense_req_q, bus_enable_q, power_on_q, ext_divider_q, fault_hiccup_q, por_fault_q;
   logic [4:0] sense_code, bus_address_q, loop_config_q, output_level_q;
   logic [1:0] sense_pin_q, soft_start_q, output_range_q;
   logic [3:0][4:0] codes;
   logic [2:0] lag;
   int err_count, comparisons, cycles;
   pin_strap_config_loader #(.burn_cycles(20)) u_dut (.*);
   strap_sensor_model u_sensor (.*);
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready_q !== 1'b1);
      rd = prdata_q;
      er = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cycle_power(input logic [4:0] code);
      int n;
      @(posedge clock);
      input_supply_ok <= 1'b0;
      bias_supply_ok <= 1'b0;
      driver_bias_rail_ok <= 1'b0;
      repeat (8) @(posedge clock);
      codes[0] <= code;
      bias_supply_ok <= 1'b1;
      driver_bias_rail_ok <= 1'b1;
      @(posedge clock);
      input_supply_ok <= 1'b1;
      n = 0;
      while (power_on_q !== 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      check("power on", power_on_q, 1'b1);
      check("bus enable", bus_enable_q, 1'b1);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic run(input logic [4:0] code, input logic [7:0] current_limit_level, input logic [1:0] ss, input logic hic, ext);
      cycle_power(code);
      check("limit", current_limit_level_q, current_limit_level);
      check("soft start", soft_start_q, ss);
      check("fault response", fault_hiccup_q, hic);
      check("divider", ext_divider_q, ext);
      check("level", output_level_q, ext ? 5'h00 : 5'h0E);
      check("range", output_range_q, ext ? 2'h0 : 2'h1);
      check("address", bus_address_q, 5'h0A);
      check("loop", loop_config_q, 5'h13);
      apb(1'b0, 8'h0C, 32'h0);
      check("threshold", rd, {24'h0, current_limit_level});
   endtask
   task automatic sources;
      apb(1'b1, 8'h00, 32'hF);
      lag <= 3'h7;
      cycle_power(5'h09);
      check("stored limit", current_limit_level_q, 8'h19);
      check("stored address", bus_address_q, 5'h00);
      check("stored level", output_level_q, 5'h00);
      apb(1'b0, 8'h00, 32'h0);
      check("select readback", rd, 32'hF);
      apb(1'b1, 8'h00, 32'h0);
      lag <= 3'h2;
   endtask
   task automatic order;
      split_rail_mode <= 1'b1;
      cycle_power(5'h07);
      enable_in <= 1'b0;
      repeat (6) @(posedge clock);
      check("enable low", power_on_q, 1'b0);
      enable_in <= 1'b1;
      repeat (6) @(posedge clock);
      check("enable high", power_on_q, 1'b1);
      bias_supply_ok <= 1'b0;
      repeat (6) @(posedge clock);
      check("bias low", power_on_q, 1'b0);
      split_rail_mode <= 1'b0;
   endtask
   task automatic burn;
      // powered up first, so the burn is cut only by the supply cycle below
      cycle_power(5'h07);
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      check("burn busy", rd, 32'h1);
      cycle_power(5'h07);
      check("corrupt flag", por_fault_q, 1'b1);
      apb(1'b1, 8'h04, 32'h1);
      repeat (40) @(posedge clock);
      cycle_power(5'h07);
      check("corrupt cleared", por_fault_q, 1'b0);
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_count++;
         print_verdict;
      end
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      input_supply_ok = 1'b0;
      bias_supply_ok = 1'b0;
      driver_bias_rail_ok = 1'b0;
      enable_in = 1'b1;
      split_rail_mode = 1'b0;
      codes = {5'h0E, 5'h13, 5'h0A, 5'h07};
      lag = 3'h2;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      run(5'h00, 8'h19, 2'h0, 1'b0, 1'b0);
      run(5'h07, 8'h14, 2'h1, 1'b1, 1'b0);
      run(5'h0A, 8'h0F, 2'h0, 1'b1, 1'b0);
      run(5'h0C, 8'h19, 2'h0, 1'b1, 1'b1);
      run(5'h12, 8'h14, 2'h2, 1'b1, 1'b1);
      run(5'h15, 8'h0F, 2'h1, 1'b1, 1'b1);
      run(5'h16, 8'h0F, 2'h3, 1'b1, 1'b1);
      sources();
      order();
      apb(1'b0, 8'h1C, 32'h0);
      check("unmapped error", er, 1'b1);
      check("unmapped data", rd, 32'h0);
      burn();
      print_verdict;
   end
endmodule
bind pin_strap_config_loader pin_strap_config_loader_chk u_chk (.*);
